// ===== lcd_drive_pkg.sv
`default_nettype none
package lcd_drive_pkg;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int COM_LINES = 4;
  localparam int SEG_LINES = 30;
  localparam int DM_COUNT = 15;
  localparam int DM_IW = 4;
  localparam logic [7:0] IDX_AUX = 8'h2f;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_DM_FIRST = 8'h31;
  localparam logic [7:0] IDX_DM_LAST = 8'h3f;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DM_RESET = 8'h00;
  localparam logic [1:0] FREQ_RESET = 2'h0;
  localparam int AUX_FREQ_LSB = 0;
  localparam int AUX_CMP_ON = 2;
  localparam int AUX_CMP_SEL = 3;
  localparam int AUX_COM_LSB = 4;
  localparam int AUX_PHASE = 6;
  localparam logic [2:0] GROUP_ALL_SEG = 3'h7;
  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] MUX_TWO = 2'h1;
  localparam logic [2:0] LVL_V5 = 3'h0;
  localparam logic [2:0] LVL_V3 = 3'h1;
  localparam logic [2:0] LVL_MID = 3'h2;
  localparam logic [2:0] LVL_V2 = 3'h3;
  localparam logic [2:0] LVL_V1 = 3'h4;
  typedef struct packed {
    logic [2:0] group_sel;
    logic [1:0] mux_sel;
    logic segment_blank_bit;
    logic unused;
    logic display_on_bit;
  } panel_ctrl_t;
  typedef enum logic [1:0] {
    GEN_OFF = 2'b01,
    GEN_RUN = 2'b10
  } gen_state_t;
endpackage
`default_nettype wire

// ===== lcd_segment_common_driver.sv
// Added by the designer: the address map and the APB interface to the registers.
`default_nettype none
module lcd_segment_common_driver
  import lcd_drive_pkg::*;
#(
  parameter int SHARED_SEG = 0
) (
  // Clock and power-up clear.
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tick from the basic timer and its rate select.
  input wire logic panel_tick,
  output logic [1:0] frame_freq_sel,
  // Panel pins as level codes and pin modes, plus comparator input select and ladder switch.
  output logic [COM_LINES-1:0][2:0] com_level,
  output logic [SEG_LINES-1:0][2:0] seg_level,
  output logic [SEG_LINES-1:0] seg_gp_mode,
  output logic comparator_input_pin,
  output logic ladder_supply_out
);

  if (SHARED_SEG < 0 || SHARED_SEG >= SEG_LINES) begin : bad_shared_seg
    $error("Shared segment index out of range.");
  end

  panel_ctrl_t ctrl;
  logic comparator_on_bit;
  logic cmp_sticky;
  logic [7:0] dm [DM_COUNT];
  gen_state_t state;
  logic [1:0] com_idx;
  logic phase;

  function automatic logic [2:0] line_group(input int line);
    line_group = (line < 2) ? 3'h0 : 3'((line + 2) / 4);
  endfunction

  function automatic logic [2:0] com_drive(input logic active, input logic ph,
                                           input logic half);
    if (active) begin
      com_drive = ph ? LVL_V5 : LVL_V1;
    end else if (half) begin
      com_drive = LVL_MID;
    end else begin
      com_drive = ph ? LVL_V2 : LVL_V3;
    end
  endfunction

  function automatic logic [2:0] seg_drive(input logic on, input logic ph,
                                           input logic third);
    if (on) begin
      seg_drive = ph ? LVL_V1 : LVL_V5;
    end else if (third) begin
      seg_drive = ph ? LVL_V3 : LVL_V2;
    end else begin
      seg_drive = ph ? LVL_V5 : LVL_V1;
    end
  endfunction

  // Bus decode.
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[APB_AW-1:10] == '0);
  wire hit_ctrl = aligned && (idx == IDX_CTRL);
  wire hit_aux = aligned && (idx == IDX_AUX);
  wire hit_dm = aligned && (idx >= IDX_DM_FIRST) && (idx <= IDX_DM_LAST);
  wire mapped = hit_ctrl || hit_aux || hit_dm;
  wire [DM_IW-1:0] dm_sel = DM_IW'(idx - IDX_DM_FIRST);
  wire access = psel && penable;
  wire wr_en = access && pwrite && mapped && pstrb[0];
  wire rd_setup = psel && !penable && !pwrite;
  wire [7:0] aux_view = {1'b0, phase, com_idx, cmp_sticky, comparator_on_bit, frame_freq_sel};
  wire [7:0] rd_byte = hit_ctrl ? ctrl : hit_aux ? aux_view : hit_dm ? dm[dm_sel] : 8'h00;

  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // Mode decode.
  wire run = (state == GEN_RUN);
  wire [1:0] mux_last = ctrl.mux_sel;
  wire half_bias = (ctrl.mux_sel == MUX_TWO);
  wire third_bias = (ctrl.mux_sel > MUX_TWO);
  wire frame_wrap = run && panel_tick && (com_idx >= mux_last);
  wire [1:0] next_com_idx = frame_wrap ? 2'h0 : 2'(com_idx + 2'h1);
  gen_state_t next_state;
  assign next_state = ctrl.display_on_bit ? GEN_RUN : GEN_OFF;

  logic [COM_LINES-1:0][2:0] next_com_level;
  logic [SEG_LINES-1:0][2:0] next_seg_level;
  logic [SEG_LINES-1:0] next_gp;

  // Each used common (index up to mux_last) is active during its own slot and dc-free over two phases; unused ones sit at LVL_V5.
  for (genvar c = 0; c < COM_LINES; c++) begin : g_com
    wire used = (2'(c) <= mux_last);
    assign next_com_level[c] = (!run || !used) ? LVL_V5 :
                               com_drive(com_idx == 2'(c), phase, !third_bias);
  end

  // Segment drive or digital output per line.
  for (genvar s = 0; s < SEG_LINES; s++) begin : g_seg
    wire [7:0] byte_v = dm[s / 2];
    wire bit_v = byte_v[(s % 2) * 4 + int'(com_idx)];
    wire seg_on = bit_v && ctrl.segment_blank_bit;
    wire is_gp = (line_group(s) > ctrl.group_sel);
    wire shared = (s == SHARED_SEG) && cmp_sticky;
    assign next_gp[s] = is_gp;
    assign next_seg_level[s] = shared ? LVL_V5 :
                               is_gp ? (bit_v ? LVL_V1 : LVL_V5) :
                               !run ? LVL_V5 :
                               seg_drive(seg_on, phase, third_bias);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
      frame_freq_sel <= FREQ_RESET;
      comparator_on_bit <= 1'b0;
    end else if (wr_en && hit_ctrl) begin
      ctrl <= pwdata[7:0];
    end else if (wr_en && hit_aux) begin
      frame_freq_sel <= pwdata[AUX_FREQ_LSB+:2];
      comparator_on_bit <= pwdata[AUX_CMP_ON];
    end
  end

  // Display memory stays ordinary storage whatever the mode.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DM_COUNT; i++) begin
        dm[i] <= DM_RESET;
      end
    end else if (wr_en && hit_dm) begin
      dm[dm_sel] <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_sticky <= 1'b0;
    end else if (comparator_on_bit) begin
      cmp_sticky <= 1'b1;
    end
  end

  // Timing generator advances only on the timer tick.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= GEN_OFF;
      com_idx <= 2'h0;
      phase <= 1'b0;
    end else begin
      state <= next_state;
      case (state)
        GEN_OFF: begin
          com_idx <= 2'h0;
          phase <= 1'b0;
        end
        GEN_RUN: begin
          if (panel_tick) begin
            com_idx <= next_com_idx;
            phase <= phase ^ frame_wrap;
          end
        end
        default: begin
          com_idx <= 2'h0;
          phase <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      com_level <= '0;
      seg_level <= '0;
      seg_gp_mode <= '0;
      comparator_input_pin <= 1'b0;
      ladder_supply_out <= 1'b0;
    end else begin
      com_level <= next_com_level;
      seg_level <= next_seg_level;
      seg_gp_mode <= next_gp;
      comparator_input_pin <= cmp_sticky;
      ladder_supply_out <= ctrl.display_on_bit;
    end
  end

  // Checks.
  sequence last_slot_tick_s;
    run && panel_tick && (com_idx == mux_last);
  endsequence

  sequence wrapped_s;
    (com_idx == 2'h0) && (phase != $past(phase));
  endsequence

  sequence cmp_set_s;
    $rose(comparator_on_bit);
  endsequence

  sequence cmp_taken_s;
    ##[1:2] comparator_input_pin;
  endsequence

  property frame_wrap_p;
    @(posedge mclk) disable iff (!reset_n)
      last_slot_tick_s |=> wrapped_s;
  endproperty

  property mid_frame_p;
    @(posedge mclk) disable iff (!reset_n)
      run && panel_tick && (com_idx < mux_last) |=> (phase == $past(phase))
        && (com_idx == $past(com_idx) + 2'h1);
  endproperty

  frame_wrap_a: assert property (frame_wrap_p)
    else $error("Frame did not wrap after last common slot.");

  frame_step_a: assert property (mid_frame_p)
    else $error("Common slot did not step on tick.");

  lines_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      !ctrl.display_on_bit [*2] |=> (com_level == '0) && !ladder_supply_out
        && (com_idx == 2'h0))
    else $error("Lines not low with display off.");

  ladder_on_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      $rose(ctrl.display_on_bit) |=> ladder_supply_out)
    else $error("Ladder switch did not close.");

  cmp_select_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      cmp_set_s |-> cmp_taken_s)
    else $error("Comparator input not selected.");

  cmp_sticky_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      comparator_input_pin |=> comparator_input_pin
        && (seg_level[SHARED_SEG] == LVL_V5))
    else $error("Comparator selection released.");

  group0_seg_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      seg_gp_mode[1:0] == 2'h0)
    else $error("Group zero left segment drive.");

  group_top_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      reset_n |=> seg_gp_mode[SEG_LINES-1] == ($past(ctrl.group_sel) != GROUP_ALL_SEG))
    else $error("Top group mode wrong.");

  gp_static_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      (seg_gp_mode[SEG_LINES-1] && (dm[DM_COUNT-1][7:4] == 4'hf)) [*2]
        |-> seg_level[SEG_LINES-1] == LVL_V1)
    else $error("Digital output not static high.");

  blank_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      run && !ctrl.segment_blank_bit && (ctrl.mux_sel == MUX_STATIC)
        && !seg_gp_mode[0] && !cmp_sticky && $stable(phase)
        |=> seg_level[0] == com_level[0])
    else $error("Blanked segment not matching common.");

  common_ac_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      run && $past(run) && (com_level[0] == LVL_V1) |-> !$past(phase))
    else $error("Common level not alternating with phase.");

  ladder_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      $fell(ctrl.display_on_bit) |=> !ladder_supply_out)
    else $error("Ladder switch did not open.");

  off_hold_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      !run |=> (com_idx == 2'h0) && !phase)
    else $error("Timing generator not held while off.");

  tick_hold_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      run && !panel_tick |=> $stable(com_idx) && $stable(phase))
    else $error("Common slot moved without a tick.");

  half_bias_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      run && (ctrl.mux_sel == MUX_TWO) && (com_idx != 2'h1) |=> com_level[1] == LVL_MID)
    else $error("Idle common not at mid level.");

  gp_low_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      (seg_gp_mode[SEG_LINES-1] && (dm[DM_COUNT-1][7:4] == 4'h0)) [*2]
        |-> seg_level[SEG_LINES-1] == LVL_V5)
    else $error("Digital output not static low.");

  cmp_hold_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
      !comparator_on_bit && !cmp_sticky |=> !cmp_sticky)
    else $error("Comparator selected without its enable.");

endmodule
`default_nettype wire

// ===== lcd_panel_model.sv
`default_nettype none
module lcd_panel_model (
  // Clock and clear.
  input wire logic mclk,
  input wire logic reset_n,
  // Rate select and tick toward the panel driver.
  input wire logic [1:0] frame_freq_sel,
  output logic panel_tick,
  output logic [15:0] tick_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] div;
  // The tick period doubles with each select step, divided down from mclk (8 << frame_freq_sel cycles).
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 8'h00;
      panel_tick <= 1'b0;
      tick_count <= 16'h0000;
    end else begin
      panel_tick <= (div == 8'h00);
      div <= (div == 8'h00) ? (8'h08 << frame_freq_sel) - 8'h01 : div - 8'h01;
      tick_count <= tick_count + {15'h0000, panel_tick};
    end
  end
endmodule
`default_nettype wire

// ===== test_lcd_segment_common_driver.sv
`default_nettype none
module test_lcd_segment_common_driver;
  import lcd_drive_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, psel, penable, pwrite, panel_tick, pready, pslverr, cmp_pin, ladder;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] freq_sel;
  logic [COM_LINES-1:0][2:0] com_level;
  logic [SEG_LINES-1:0][2:0] seg_level;
  logic [SEG_LINES-1:0] seg_gp_mode;
  logic [15:0] tick_count, t0;
  logic err, ph;
  int fail_count, n_checks, same;
  lcd_segment_common_driver u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel_tick(panel_tick),
    .frame_freq_sel(freq_sel), .com_level(com_level), .seg_level(seg_level),
    .seg_gp_mode(seg_gp_mode), .comparator_input_pin(cmp_pin), .ladder_supply_out(ladder));
  lcd_panel_model u_panel (.mclk(mclk), .reset_n(reset_n), .frame_freq_sel(freq_sel),
    .panel_tick(panel_tick), .tick_count(tick_count));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fail_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask
  task automatic count_same(input int n);
    same = 0;
    repeat (n) begin
      @(negedge mclk);
      if (seg_level[0] === com_level[0]) same++;
    end
  endtask
  task automatic wait_phase;
    int i;
    apb(1'b0, IDX_AUX, 8'h00);
    ph = rd[AUX_PHASE];
    i = 0;
    do begin
      apb(1'b0, IDX_AUX, 8'h00);
      i++;
    end while (rd[AUX_PHASE] === ph && i < 200);
    if (i >= 200) begin
      fail_count++;
      results();
    end
  endtask
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fail_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    check(seg_gp_mode, 32'h3ffffffc);
    check(cmp_pin, 1'b0);
    rdc(IDX_CTRL, CTRL_RESET);
    rdc(IDX_AUX, 8'h00);
    apb(1'b0, 8'h01, 8'h00);
    check({err, rd[7:0]}, 9'h100);
    for (int k = 0; k < DM_COUNT; k++) begin
      apb(1'b1, IDX_DM_FIRST + k[7:0], 8'h5a ^ k[7:0]);
      rdc(IDX_DM_FIRST + k[7:0], 8'h5a ^ k[7:0]);
    end
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, IDX_CTRL, {n[2:0], 5'h00});
      repeat (3) @(posedge mclk);
      check(seg_gp_mode, (n == 7) ? 32'h0 : {2'h0, 30'h3fffffff << (4 * n + 2)});
    end
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, 8'h36, 8'hff);
    apb(1'b1, IDX_DM_LAST, 8'hff);
    repeat (3) @(posedge mclk);
    check(seg_level[10], LVL_V1);
    check(seg_level[SEG_LINES-1], LVL_V1);
    apb(1'b1, 8'h36, 8'h00);
    repeat (3) @(posedge mclk);
    check(seg_level[10], LVL_V5);
    check({com_level, ladder}, 13'h0000);
    apb(1'b1, 8'h36, 8'hff);
    apb(1'b1, IDX_CTRL, 8'h01);
    repeat (3) @(posedge mclk);
    check(ladder, 1'b1);
    check(seg_level[10], LVL_V1);
    apb(1'b1, IDX_AUX, 8'h01);
    @(posedge mclk);
    check(freq_sel, 2'h1);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, IDX_CTRL, {3'h0, m[1:0], 3'h5});
      wait_phase();
      t0 = tick_count;
      wait_phase();
      check(tick_count - t0, m + 1);
    end
    apb(1'b1, IDX_DM_FIRST, 8'h01);
    apb(1'b1, IDX_CTRL, 8'h05);
    repeat (3) @(posedge mclk);
    count_same(64);
    check(same, 0);
    apb(1'b1, IDX_DM_FIRST, 8'h00);
    repeat (3) @(posedge mclk);
    count_same(64);
    check(same, 64);
    apb(1'b1, IDX_DM_FIRST, 8'h01);
    apb(1'b1, IDX_CTRL, 8'h01);
    repeat (3) @(posedge mclk);
    count_same(64);
    check(same, 64);
    apb(1'b1, IDX_AUX, 8'h05);
    apb(1'b1, IDX_AUX, 8'h01);
    repeat (2) @(posedge mclk);
    check(cmp_pin, 1'b1);
    apb(1'b0, IDX_AUX, 8'h00);
    check({rd[7], rd[5:0]}, 7'h09);
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    check({cmp_pin, ladder, freq_sel}, 4'h0);
    results();
  end
endmodule
`default_nettype wire
